/* File: rtl/ohbwc_top.sv */
// dual-role event, interrupt, wake, host state and root port logic
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ohbwc_top #(
  parameter int FRAME_CYCLES = ohbwc_pkg::FRAME_CYC_DOC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [ohbwc_pkg::STATUS_W-1:0] dual_role_status_pins,
  input wire logic [1:0] port_attach_pins,
  input wire logic port1_role_select_pin,
  input wire logic cable_role_sense_pin,
  output logic shared_irq_pin_o,
  output logic shared_irq_pin_oe,
  output logic [15:0] dual_role_control_out,
  output ohbwc_pkg::ohbwc_power_t power_ctl,
  output logic [1:0] port1_role,
  output logic port2_negotiation_ignore,
  output logic traffic_enable,
  output logic sof_pulse
);
  import ohbwc_pkg::*;

  typedef enum logic {PW_AWAKE, PW_SAVE} ohbwc_pw_t;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  logic [7:0] wr_addr_reg;
  logic wr_pend_reg;
  wire addr_phase = hsel & htrans[1] & hready;
  wire bus_wr = wr_pend_reg;
  wire [31:0] read_word;
  wire wr_ctl = bus_wr & is_addr(wr_addr_reg, ADDR_DR_CONTROL);
  wire wr_flags = bus_wr & is_addr(wr_addr_reg, ADDR_DR_FLAGS);
  wire wr_mask = bus_wr & is_addr(wr_addr_reg, ADDR_DR_MASK);
  wire wr_timer = bus_wr & is_addr(wr_addr_reg, ADDR_DR_TIMER);
  wire wr_cfg = bus_wr & is_addr(wr_addr_reg, ADDR_PIN_CFG);
  wire wr_cpu_flags = bus_wr & is_addr(wr_addr_reg, ADDR_CPU_FLAGS);
  wire wr_cpu_mask = bus_wr & is_addr(wr_addr_reg, ADDR_CPU_MASK);
  wire wr_host = bus_wr & is_addr(wr_addr_reg, ADDR_HOST_CTL);
  wire wr_power = bus_wr & is_addr(wr_addr_reg, ADDR_POWER);
  wire [1:0] wr_port = {bus_wr & is_addr(wr_addr_reg, ADDR_PORT2), bus_wr & is_addr(wr_addr_reg, ADDR_PORT1)};

  // single-cycle data phase; a read right behind a write sees the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (addr_phase & !hwrite) begin
        hrdata <= read_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // slow idle divider and event timer tick
  // ----------------------------------------------------------------
  logic [15:0] idle_div_reg;
  logic [15:0] tick_div_reg;
  wire idle_tick = idle_div_reg == 16'(IDLE_DIV_CYC - 1);
  wire timer_tick = tick_div_reg == 16'(TIMER_TICK_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_div_reg <= 16'h0000;
      tick_div_reg <= 16'h0000;
    end else begin
      idle_div_reg <= idle_tick ? 16'h0000 : idle_div_reg + 16'h0001; // R10
      tick_div_reg <= timer_tick ? 16'h0000 : tick_div_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // status pins, change flags, timer
  // ----------------------------------------------------------------
  logic [STATUS_W-1:0] status_meta_reg;
  logic [STATUS_W-1:0] status_sync_reg;
  logic [STATUS_W-1:0] status_prev_reg;
  logic [8:0] flags_reg;
  logic [8:0] mask_reg;
  logic [15:0] ctl_reg;
  logic [TIMER_W-1:0] timer_reg;
  wire [STATUS_W-1:0] status_change = status_sync_reg ^ status_prev_reg;
  wire timer_expire = timer_tick & (timer_reg == TIMER_W'(1));
  wire [8:0] flags_set = {timer_expire, status_change};
  wire [8:0] flags_next = (flags_reg & ~(wr_flags ? hwdata[8:0] : 9'h000)) | flags_set; // R2
  wire otg_any = |(flags_reg & mask_reg); // R5

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_meta_reg <= '0;
      status_sync_reg <= '0;
      status_prev_reg <= '0;
      flags_reg <= 9'h000;
      mask_reg <= 9'h000;
      ctl_reg <= 16'h0000;
      timer_reg <= '0;
    end else begin
      status_meta_reg <= dual_role_status_pins;
      status_sync_reg <= status_meta_reg;
      status_prev_reg <= status_sync_reg;
      flags_reg <= flags_next;
      if (wr_mask) begin
        mask_reg <= hwdata[8:0];
      end
      if (wr_ctl) begin
        ctl_reg <= hwdata[15:0];
      end
      if (wr_timer) begin
        timer_reg <= hwdata[TIMER_W-1:0];
      end else if (timer_tick && timer_reg != '0) begin
        timer_reg <= timer_reg - TIMER_W'(1); // R1
      end
    end
  end

  // ----------------------------------------------------------------
  // shared interrupt pin
  // ----------------------------------------------------------------
  logic [5:0] cfg_reg;
  logic [15:0] cpu_mask_reg;
  logic sof_flag_reg;
  logic irq_active_reg;
  wire [15:0] cpu_flags = {6'h00, otg_any, 6'h00, sof_flag_reg, 2'h0}; // R6
  wire irq_active = |(cpu_flags & cpu_mask_reg); // R3
  wire irq_assert = cfg_reg[CFG_EDGE] ? (irq_active & !irq_active_reg) : irq_active; // R4
  wire frame_end;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= PIN_CFG_RST;
      cpu_mask_reg <= 16'h0000;
      sof_flag_reg <= 1'b0;
      irq_active_reg <= 1'b0;
      shared_irq_pin_o <= 1'b1;
      shared_irq_pin_oe <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= hwdata[5:0]; // R18
      end
      if (wr_cpu_mask) begin
        cpu_mask_reg <= hwdata[15:0];
      end
      sof_flag_reg <= (sof_flag_reg & !(wr_cpu_flags & hwdata[CPU_SOF])) | frame_end;
      irq_active_reg <= irq_active;
      shared_irq_pin_o <= irq_assert ~^ cfg_reg[CFG_HIGH]; // R4
      shared_irq_pin_oe <= cfg_reg[CFG_PIN_EN]; // R7
    end
  end

  // ----------------------------------------------------------------
  // power saving and wake
  // ----------------------------------------------------------------
  ohbwc_pw_t pw_reg;
  ohbwc_pw_t pw_next;
  logic wake_pend_reg;
  wire [STATUS_W-1:0] wake_sel = STATUS_W'((1 << ST_ID) | (1 << ST_B_SESS_VLD) | (1 << ST_SRP_DET));
  wire wake_event = |(flags_reg[STATUS_W-1:0] & mask_reg[STATUS_W-1:0] & wake_sel); // R11
  wire bus_touch = hsel & htrans[1]; // R12

  always_comb begin
    pw_next = pw_reg;
    case (pw_reg)
      PW_AWAKE: begin
        if (wr_power && hwdata[0]) begin
          pw_next = PW_SAVE;
        end
      end
      PW_SAVE: begin
        if (bus_touch || wake_pend_reg) begin
          pw_next = PW_AWAKE; // R10 R12
        end
      end
      default: pw_next = PW_AWAKE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_reg <= PW_AWAKE;
      wake_pend_reg <= 1'b0;
      power_ctl <= '{host_suspend: 1'b0, periph_suspend: 1'b0, pll_enable: 1'b1,
                     osc_enable: 1'b1, pump_suspend: 1'b0};
    end else begin
      pw_reg <= pw_next;
      // status wake events are only looked at on the slow idle clock; a bus access wakes at once
      wake_pend_reg <= (pw_reg == PW_SAVE) & (wake_pend_reg | (idle_tick & wake_event)); // R10
      power_ctl.host_suspend <= pw_next == PW_SAVE; // R9
      power_ctl.periph_suspend <= pw_next == PW_SAVE;
      power_ctl.pll_enable <= pw_next == PW_AWAKE;
      power_ctl.osc_enable <= pw_next == PW_AWAKE;
      power_ctl.pump_suspend <= pw_next == PW_SAVE;
    end
  end

  // ----------------------------------------------------------------
  // host bus states, frame counter, start-of-frame
  // ----------------------------------------------------------------
  logic [10:0] host_ctl_reg;
  logic [15:0] frame_reg;
  logic [31:0] frame_cyc_reg;
  wire [1:0] host_functional_state = host_ctl_reg[HOST_FUNCTIONAL_STATE_LSB+1:HOST_FUNCTIONAL_STATE_LSB]; // R13
  wire oper = (host_functional_state == HOST_FUNCTIONAL_STATE_OPER) & (pw_reg == PW_AWAKE); // R14
  assign frame_end = oper & (frame_cyc_reg == 32'(FRAME_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_ctl_reg <= HOST_CTL_RST;
      frame_reg <= 16'h0000;
      frame_cyc_reg <= 32'h0000_0000;
      traffic_enable <= 1'b0;
      sof_pulse <= 1'b0;
    end else begin
      if (wr_host) begin
        host_ctl_reg <= hwdata[10:0]; // R17
      end
      if (!oper || frame_end) begin
        frame_cyc_reg <= 32'h0000_0000;
      end else begin
        frame_cyc_reg <= frame_cyc_reg + 32'h0000_0001;
      end
      if (frame_end) begin
        frame_reg <= frame_reg + 16'h0001; // R16
      end
      traffic_enable <= oper; // R14
      sof_pulse <= frame_end; // R15
    end
  end

  // ----------------------------------------------------------------
  // root hub ports
  // ----------------------------------------------------------------
  logic [1:0] attach_meta_reg;
  logic [1:0] attach_sync_reg;
  logic [1:0] ccs_reg;
  logic [1:0] pes_reg;
  logic [1:0] prs_reg;
  logic [1:0] csc_reg;
  logic [3:0] rst_frames_reg [2];
  wire [31:0] port_word [2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      attach_meta_reg <= 2'h0;
      attach_sync_reg <= 2'h0;
    end else begin
      attach_meta_reg <= port_attach_pins;
      attach_sync_reg <= attach_meta_reg;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      wire w = wr_port[gp];
      wire rst_done = prs_reg[gp] & frame_end & (rst_frames_reg[gp] == 4'(PORT_RESET_FRAMES - 1));
      assign port_word[gp] = {15'h0000, csc_reg[gp], 7'h00, 1'b1, 3'h0, prs_reg[gp], 2'h0,
                              pes_reg[gp], ccs_reg[gp]}; // R19
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ccs_reg[gp] <= 1'b0;
          pes_reg[gp] <= 1'b0;
          prs_reg[gp] <= 1'b0;
          csc_reg[gp] <= PORT_CSC_RST;
          rst_frames_reg[gp] <= 4'h0;
        end else begin
          ccs_reg[gp] <= attach_sync_reg[gp];
          // a connect change arriving with the clear keeps the flag
          csc_reg[gp] <= (csc_reg[gp] & !(w & hwdata[P_CSC])) | (ccs_reg[gp] ^ attach_sync_reg[gp]);
          if (!ccs_reg[gp] || (w && hwdata[P_CCS])) begin
            pes_reg[gp] <= 1'b0;
          end else if ((w && hwdata[P_PES]) || rst_done) begin
            pes_reg[gp] <= 1'b1; // R20
          end
          if (!ccs_reg[gp] || rst_done) begin
            prs_reg[gp] <= 1'b0;
          end else if (w && hwdata[P_PRS]) begin
            prs_reg[gp] <= 1'b1;
          end
          if (!prs_reg[gp]) begin
            rst_frames_reg[gp] <= 4'h0;
          end else if (frame_end) begin
            rst_frames_reg[gp] <= rst_frames_reg[gp] + 4'h1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // port roles and register outputs
  // ----------------------------------------------------------------
  logic [1:0] role_meta_reg;
  logic [1:0] role_sync_reg;
  wire [1:0] role_next = !role_sync_reg[1] ? ROLE_OTG : (role_sync_reg[0] ? ROLE_PERIPH : ROLE_HOST); // R21

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      role_meta_reg <= 2'h0;
      role_sync_reg <= 2'h0;
      port1_role <= ROLE_OTG;
      port2_negotiation_ignore <= 1'b1;
      dual_role_control_out <= 16'h0000;
    end else begin
      role_meta_reg <= {port1_role_select_pin, cable_role_sense_pin};
      role_sync_reg <= role_meta_reg;
      port1_role <= role_next;
      // negotiation status comes from port 1 only; port 2 stays a plain host port
      port2_negotiation_ignore <= 1'b1; // R22
      dual_role_control_out <= ctl_reg;
    end
  end

  assign read_word =
    is_addr(haddr[7:0], ADDR_DR_CONTROL) ? {16'h0000, ctl_reg} :
    is_addr(haddr[7:0], ADDR_DR_STATUS) ? {24'h000000, status_sync_reg} : // R8
    is_addr(haddr[7:0], ADDR_DR_FLAGS) ? {23'h000000, flags_reg} :
    is_addr(haddr[7:0], ADDR_DR_MASK) ? {23'h000000, mask_reg} :
    is_addr(haddr[7:0], ADDR_DR_TIMER) ? {16'h0000, timer_reg} :
    is_addr(haddr[7:0], ADDR_PIN_CFG) ? {26'h0000000, cfg_reg} :
    is_addr(haddr[7:0], ADDR_CPU_FLAGS) ? {16'h0000, cpu_flags} :
    is_addr(haddr[7:0], ADDR_CPU_MASK) ? {16'h0000, cpu_mask_reg} :
    is_addr(haddr[7:0], ADDR_HOST_CTL) ? {21'h000000, host_ctl_reg} :
    is_addr(haddr[7:0], ADDR_FRAME) ? {16'h0000, frame_reg} :
    is_addr(haddr[7:0], ADDR_PORT1) ? port_word[0] :
    is_addr(haddr[7:0], ADDR_PORT2) ? port_word[1] :
    is_addr(haddr[7:0], ADDR_POWER) ? {31'h00000000, pw_reg == PW_SAVE} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_timer_hold;
    @(posedge hclk) disable iff (!hresetn)
      (!timer_tick && !wr_timer) |=> (timer_reg == $past(timer_reg));
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer moved without tick"); // R1

  property p_timer_flag;
    @(posedge hclk) disable iff (!hresetn)
      (timer_tick && timer_reg == TIMER_W'(1) && !wr_timer) |=> (flags_reg[FLAG_TIMER] && timer_reg == '0);
  endproperty
  a_timer_flag: assert property (p_timer_flag) else $error("timer expiry not flagged"); // R2

  property p_change_flag;
    @(posedge hclk) disable iff (!hresetn)
      (status_change != '0) |=> ((flags_reg[STATUS_W-1:0] & $past(status_change)) == $past(status_change));
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("status change lost"); // R2

  property p_pin_off;
    @(posedge hclk) disable iff (!hresetn)
      !cfg_reg[CFG_PIN_EN] |=> !shared_irq_pin_oe;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled"); // R7

  property p_level_high;
    @(posedge hclk) disable iff (!hresetn)
      (cfg_reg[2:0] == 3'h5 && cpu_mask_reg[CPU_DR] && otg_any) |=> (shared_irq_pin_o && shared_irq_pin_oe);
  endproperty
  a_level_high: assert property (p_level_high) else $error("pin not asserted high"); // R3

  property p_bus_wake;
    @(posedge hclk) disable iff (!hresetn)
      (pw_reg == PW_SAVE && bus_touch) |=> (pw_reg == PW_AWAKE) ##1 power_ctl.pll_enable;
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("bus access did not wake"); // R12

  property p_no_wake;
    @(posedge hclk) disable iff (!hresetn)
      (pw_reg == PW_SAVE && !bus_touch && !wake_pend_reg && !wake_event) |=> (pw_reg == PW_SAVE);
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("woke without enabled event"); // R11

  property p_save_clocks;
    @(posedge hclk) disable iff (!hresetn)
      (pw_reg == PW_SAVE && $past(pw_reg) == PW_SAVE) |-> (!power_ctl.pll_enable && power_ctl.host_suspend);
  endproperty
  a_save_clocks: assert property (p_save_clocks) else $error("clocks running in power save"); // R9

  property p_sof_oper;
    @(posedge hclk) disable iff (!hresetn)
      sof_pulse |-> ($past(oper) && frame_reg == $past(frame_reg) + 16'h0001);
  endproperty
  a_sof_oper: assert property (p_sof_oper) else $error("frame or sof outside operation"); // R15

  property p_role;
    @(posedge hclk) disable iff (!hresetn)
      (role_sync_reg == 2'h2) |=> (port1_role == ROLE_HOST);
  endproperty
  a_role: assert property (p_role) else $error("port 1 role wrong"); // R21
endmodule // ohbwc_top
`default_nettype wire

/* File: rtl/ohbwc_pkg.sv */
// constants, types and register map of the dual-role control block
// Summary of operation
// (R1) programmable event timer, 0.01 ms base
// (R2) flag every status change and timer expiry
// (R3) both interrupt sources share one pin
// (R4) pin polarity and edge mode configurable
// (R5) per-flag enable bits zero through eight
// (R6) combined dual-role interrupt at bit nine
// (R7) pin driven only with master enable
// (R8) software reads flags then status levels
// (R9) power saving stops clocks, suspends controllers
// (R10) slow idle clock samples wake events
// (R11) only enabled status changes wake device; the code wakes only on enabled ST_ID, ST_B_SESS_VLD and ST_SRP_DET changes
// (R12) any register access wakes device
// (R13) four host bus states in control
// (R14) traffic only while operational
// (R15) start-of-frame generated by hardware
// (R16) frame number advances every millisecond
// (R17) writing 0680h makes host operational
// (R18) writing 002Dh gives level, high, enabled
// (R19) port reads 00010100h, connect 00010101h
// (R20) writing 00000102h enables, reads 00010103h
// (R21) port 1 role from two pins
// (R22) port 2 always downstream, ignores negotiation
package ohbwc_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_DR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_DR_TIMER = 8'h10;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h14;
  localparam logic [7:0] ADDR_CPU_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_CPU_MASK = 8'h1c;
  localparam logic [7:0] ADDR_HOST_CTL = 8'h20;
  localparam logic [7:0] ADDR_FRAME = 8'h24;
  localparam logic [7:0] ADDR_PORT1 = 8'h28;
  localparam logic [7:0] ADDR_PORT2 = 8'h2c;
  localparam logic [7:0] ADDR_POWER = 8'h30;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int STATUS_W = 8;
  localparam int FLAG_TIMER = 8;
  localparam int ST_ID = 0;
  localparam int ST_B_SESS_VLD = 3;
  localparam int ST_SRP_DET = 4;
  localparam int CPU_SOF = 2;
  localparam int CPU_DR = 9;
  localparam int CFG_PIN_EN = 0;
  localparam int CFG_EDGE = 1;
  localparam int CFG_HIGH = 2;
  localparam int HOST_FUNCTIONAL_STATE_LSB = 6;
  localparam int P_CCS = 0;
  localparam int P_PES = 1;
  localparam int P_PRS = 4;
  localparam int P_PPS = 8;
  localparam int P_CSC = 16;
  localparam logic [1:0] HOST_FUNCTIONAL_STATE_RESET = 2'h0;
  localparam logic [1:0] HOST_FUNCTIONAL_STATE_RESUME = 2'h1;
  localparam logic [1:0] HOST_FUNCTIONAL_STATE_OPER = 2'h2;
  localparam logic [1:0] HOST_FUNCTIONAL_STATE_SUSPEND = 2'h3;
  localparam logic [1:0] ROLE_OTG = 2'h0;
  localparam logic [1:0] ROLE_HOST = 2'h1;
  localparam logic [1:0] ROLE_PERIPH = 2'h2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] PIN_CFG_RST = 6'h00;
  localparam logic [10:0] HOST_CTL_RST = 11'h000;
  localparam logic PORT_CSC_RST = 1'b1;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam real TIMER_BASE_MS = 0.01;
  localparam int TIMER_TICK_CYC = int'(TIMER_BASE_MS * CLK_HZ / 1000.0);
  localparam real FRAME_MS = 1.0;
  localparam int FRAME_CYC_DOC = int'(FRAME_MS * CLK_HZ / 1000.0);
  localparam real IDLE_CLK_KHZ = 110.0;
  localparam int IDLE_DIV_CYC = int'(CLK_HZ / (IDLE_CLK_KHZ * 1000.0));
  localparam int PORT_RESET_FRAMES = 10;
  localparam int TIMER_W = 16;
  // ----------------------------------------------------------------
  // power outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic host_suspend;
    logic periph_suspend;
    logic pll_enable;
    logic osc_enable;
    logic pump_suspend;
  } ohbwc_power_t;
endpackage

/* File: verif/ohbwc_cpu_model.sv */
// bus master model of the external processor on the register bus
`timescale 1ns/1ps
`default_nettype none
module ohbwc_cpu_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // waits for hready at a rising edge, bounded so a stuck slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) tb_ohbwc_top.hang();
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    // released lines show junk, not the last value
    hwdata <= ~d;
    haddr <= ~{24'h0, a};
  endtask
endmodule // ohbwc_cpu_model
`default_nettype wire

/* File: verif/tb_ohbwc_top.sv */
// self-checking bench of the dual-role control block
`timescale 1ns/1ps
`default_nettype none
module tb_ohbwc_top;
  import ohbwc_pkg::*;
  localparam int FC = 50;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} ohbwc_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, irq_o, irq_oe, p2i, traf, sof;
  logic rsel = 1'b0;
  logic rsense = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, role;
  logic [1:0] att = 2'h0;
  logic [2:0] hsize;
  logic [7:0] st = 8'h0;
  logic [15:0] ctl_out;
  ohbwc_power_t pwr;
  int errors = 0;
  int compares = 0;
  ohbwc_row_t rows [7] = '{'{ADDR_PORT1, 1'b0, 32'h0, 32'h00010100}, '{ADDR_PORT2, 1'b0, 32'h0, 32'h00010100},
    '{ADDR_PIN_CFG, 1'b1, 32'h2d, 32'h2d}, '{ADDR_DR_MASK, 1'b1, 32'h1ff, 32'h1ff},
    '{ADDR_CPU_MASK, 1'b1, 32'h200, 32'h200}, '{ADDR_HOST_CTL, 1'b1, 32'h680, 32'h680},
    '{8'h3c, 1'b1, 32'h55, 32'h0}};
  logic [1:0] host_functional_state [4] = '{HOST_FUNCTIONAL_STATE_RESET, HOST_FUNCTIONAL_STATE_SUSPEND, HOST_FUNCTIONAL_STATE_RESUME, HOST_FUNCTIONAL_STATE_OPER};
  always #20 hclk = ~hclk;
  ohbwc_cpu_model cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  ohbwc_top #(.FRAME_CYCLES(FC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dual_role_status_pins(st),
    .port_attach_pins(att), .port1_role_select_pin(rsel), .cable_role_sense_pin(rsense),
    .shared_irq_pin_o(irq_o), .shared_irq_pin_oe(irq_oe), .dual_role_control_out(ctl_out),
    .power_ctl(pwr), .port1_role(role), .port2_negotiation_ignore(p2i), .traffic_enable(traf),
    .sof_pulse(sof));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hang();
    errors++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    cpu.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] f0;
    logic [31:0] f1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk({30'h0, irq_oe, irq_o}, 32'h1);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    chk({29'h0, hresp, irq_oe, irq_o}, 32'h2);
    chk({31'h0, traf}, 32'h1);
    for (int n = 0; sof !== 1'b1; n++) begin
      if (n > 2 * FC) hang();
      @(posedge hclk);
    end
    cpu.xfer(1'b0, ADDR_FRAME, 32'h0, f0);
    repeat (FC - 3) @(posedge hclk);
    cpu.xfer(1'b0, ADDR_FRAME, 32'h0, f1);
    chk(f1 - f0, 32'h1);
    st[ST_ID] <= 1'b1;
    repeat (5) @(posedge hclk);
    chk({31'h0, irq_o}, 32'h1);
    rc(ADDR_CPU_FLAGS, 32'h204);
    rc(ADDR_DR_FLAGS, 32'h1);
    rc(ADDR_DR_STATUS, 32'h1);
    wr(ADDR_DR_FLAGS, 32'h1ff);
    wr(ADDR_DR_MASK, 32'h1fe);
    st[ST_ID] <= 1'b0;
    repeat (5) @(posedge hclk);
    rc(ADDR_DR_FLAGS, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    wr(ADDR_DR_FLAGS, 32'h1ff);
    wr(ADDR_DR_TIMER, 32'h2);
    // shorter than one timer tick plus the read, so at most one tick has passed
    repeat (200) @(posedge hclk);
    rc(ADDR_DR_FLAGS, 32'h0);
    repeat (300) @(posedge hclk);
    rc(ADDR_DR_FLAGS, 32'h100);
    foreach (host_functional_state[i]) begin
      wr(ADDR_HOST_CTL, {24'h0, host_functional_state[i], 6'h0});
      rc(ADDR_HOST_CTL, {24'h0, host_functional_state[i], 6'h0});
      chk({31'h0, traf}, {31'h0, host_functional_state[i] == HOST_FUNCTIONAL_STATE_OPER});
    end
    att[0] <= 1'b1;
    repeat (5) @(posedge hclk);
    rc(ADDR_PORT1, 32'h00010101);
    rc(ADDR_PORT2, 32'h00010100);
    wr(ADDR_PORT1, 32'h00000102);
    rc(ADDR_PORT1, 32'h00010103);
    for (int i = 0; i < 4; i++) begin
      {rsel, rsense} <= i[1:0];
      repeat (5) @(posedge hclk);
      chk({30'h0, role}, {30'h0, i[1] ? (i[0] ? ROLE_PERIPH : ROLE_HOST) : ROLE_OTG});
    end
    chk({31'h0, p2i}, 32'h1);
    wr(ADDR_POWER, 32'h1);
    @(posedge hclk);
    chk({27'h0, pwr}, 32'h19);
    st[ST_B_SESS_VLD] <= 1'b1;
    repeat (240) @(posedge hclk);
    chk({27'h0, pwr}, 32'h06);
    wr(ADDR_DR_MASK, 32'h0);
    wr(ADDR_POWER, 32'h1);
    st[ST_SRP_DET] <= 1'b1;
    repeat (240) @(posedge hclk);
    chk({27'h0, pwr}, 32'h19);
    rc(ADDR_DR_MASK, 32'h0);
    chk({27'h0, pwr}, 32'h06);
    rc(ADDR_POWER, 32'h0);
    conclude();
  end
endmodule // tb_ohbwc_top
`default_nettype wire
